// ---- verilog/pwmtic_top.sv ----
// Purpose: 12-bit pwm timer with input capture, avalon-mm register slave
// Assumes: byte addressing, index = address[9:2]; one wait state per access
// Notes: mode and output attributes apply at cycle end while running
//
// Behaviour
// R1: pwm mode: run bit set starts counter at zero; clear stops and zeroes it
// R2: clearing run lets current cycle finish; bit reads set until stopped
// R3: capture mode: run bit is overflow flag, set on wrap from max to zero
// R4: pwm mode: pending flag set when counter hits period and wraps
// R5: capture mode: pending flag set on every selected capture edge
// R6: irq from pending flag in pwm; pending or overflow in capture
// R7: irq stays asserted while any enabled pending flag remains set
// R8: writing one leaves a flag unchanged, writing zero clears it
// R9: software changes irq enable by whole-byte write with ones on flags
// R10: bit 7 selects mode; pwm bits 5 and 6 enable outputs one and two
// R11: capture mode: bit 5 enables output one, bit 6 selects edge
// R12: bit 0 routes adc strobe to shared pin, else normal io data
// R13: counter advances once per prescaled timer clock tick
// R14: pwm cycle counts zero up to period then wraps to zero
// R15: both bridge outputs and adc strobe rest when timer starts or stops
// R16: compares run against both compare registers only while running
// R17: compare a raises bridge outputs, compare b raises strobe, till period
// R18: dead time between output one and two edges, both directions
// R19: capture edge copies counter into period after synchronisation
// R20: capture mode counts free 0 to max until disabled pwm selected
// R21: reset clears control register, stopped pwm, all disabled
// R22: control bit 1 reads zero and ignores writes
//
// Added by the designer: register access over Avalon-MM.
`default_nettype none
module pwmtic_top import pwmtic_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic capture_pin_in,
  input wire logic gpio_strobe_pin_data_in,
  output logic bridge_output_one_out,
  output logic bridge_output_two_out,
  output logic bridge_two_drive_out,
  output logic adc_strobe_out,
  output logic strobe_pin_out,
  output logic timer_interrupt_out
);
  typedef struct packed {
    pwmtic_ctrl_type ctrl;
    pwmtic_attr_type act;
    logic running;
    logic stop_req;
    logic dt_phase;
    logic dt_hold;
    logic [COUNT_W-1:0] period;
    logic [COUNT_W-1:0] cmp_a;
    logic [COUNT_W-1:0] cmp_b;
    logic [COUNT_W-1:0] counter;
    logic [DT_W-1:0] dead;
    logic [SEL_W-1:0] sel;
    logic [DIV_W-1:0] div;
    logic out_one;
    logic out_two;
    logic adc;
    logic strobe_pin;
    logic two_drive;
    logic irq;
    logic wait_req;
    logic [31:0] rdata;
  } pwmtic_state_type;

  pwmtic_state_type r_reg;
  pwmtic_state_type r_next;
  logic tick;
  logic cap_edge;
  logic dt_start;
  logic dt_done;
  logic dt_done_now;
  logic [IDX_W-1:0] idx;
  logic bus_req;
  logic do_wr;
  logic [7:0] wd;

  // ==========================================================
  // helpers
  function automatic pwmtic_attr_type attr_of(input pwmtic_ctrl_type c);
    pwmtic_attr_type a;
    a.capture = c.mode_select_bit;
    a.en_one = c.first_output_enable_bit;
    a.en_two = c.second_output_or_edge_bit && !c.mode_select_bit;
    a.falling = c.second_output_or_edge_bit && c.mode_select_bit;
    a.route = c.strobe_pin_route;
    return a;
  endfunction

  function automatic logic [COUNT_W-1:0] merge12(input logic [COUNT_W-1:0] old,
                                                input logic [31:0] d, input logic [3:0] be);
    logic [COUNT_W-1:0] m;
    m = old;
    if (be[0]) begin
      m[7:0] = d[7:0];
    end
    if (be[1]) begin
      m[11:8] = d[11:8];
    end
    return m;
  endfunction

  function automatic logic [7:0] ctrl_read(input pwmtic_ctrl_type c);
    logic [7:0] v;
    v = 8'h00;
    v[MODE_BIT] = c.mode_select_bit;
    v[EDGE_BIT] = c.second_output_or_edge_bit;
    v[OUT1_BIT] = c.first_output_enable_bit;
    v[RUN_BIT] = c.run_or_overflow_bit;
    v[PEND_BIT] = c.period_capture_pending;
    v[IRQEN_BIT] = c.timer_irq_enable;
    v[ROUTE_BIT] = c.strobe_pin_route;
    return v;
  endfunction

  // ==========================================================
  // prescaled timer tick
  assign tick = (r_reg.div & DIV_W'((8'h01 << r_reg.sel) - 8'h01))
              == DIV_W'((8'h01 << r_reg.sel) - 8'h01); // R13

  // ==========================================================
  // sub blocks
  pwmtic_edge_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(capture_pin_in),
    .falling_in(r_reg.act.falling),
    .edge_out(cap_edge)
  );

  pwmtic_dead_time u_dead (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick),
    .start_in(dt_start),
    .count_in(r_reg.dead),
    .done_out(dt_done)
  );

  // ==========================================================
  // bus decode
  assign idx = avs_address_in[9:2];
  assign bus_req = avs_read_in || avs_write_in;
  assign do_wr = avs_write_in && !r_reg.wait_req;
  assign wd = avs_writedata_in[7:0];

  // ==========================================================
  // next state
  always_comb begin
    r_next = r_reg;
    dt_start = 1'b0;
    r_next.div = DIV_W'(r_reg.div + 7'h01);

    // bus handshake: one wait cycle; read data loads as waitrequest drops, the write one edge later
    r_next.wait_req = !(bus_req && r_reg.wait_req);
    if (bus_req && r_reg.wait_req) begin
      r_next.rdata = 32'h0000_0000;
      case (idx)
        CTRL_IDX: r_next.rdata[7:0] = ctrl_read(r_reg.ctrl); // R22
        DEAD_IDX: r_next.rdata[DT_W-1:0] = r_reg.dead;
        PERIOD_IDX: r_next.rdata[COUNT_W-1:0] = r_reg.period;
        CMPA_IDX: r_next.rdata[COUNT_W-1:0] = r_reg.cmp_a;
        CMPB_IDX: r_next.rdata[COUNT_W-1:0] = r_reg.cmp_b;
        PRESCALE_REGISTER_IDX: r_next.rdata[SEL_W-1:0] = r_reg.sel;
        COUNT_IDX: r_next.rdata[COUNT_W-1:0] = r_reg.counter;
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end

    // register writes
    if (do_wr) begin
      case (idx)
        DEAD_IDX: begin
          if (avs_byteenable_in[0]) begin
            r_next.dead = wd[DT_W-1:0];
          end
        end
        PERIOD_IDX: r_next.period = merge12(r_reg.period, avs_writedata_in, avs_byteenable_in);
        CMPA_IDX: r_next.cmp_a = merge12(r_reg.cmp_a, avs_writedata_in, avs_byteenable_in);
        CMPB_IDX: r_next.cmp_b = merge12(r_reg.cmp_b, avs_writedata_in, avs_byteenable_in);
        PRESCALE_REGISTER_IDX: begin
          if (avs_byteenable_in[0]) begin
            r_next.sel = wd[SEL_W-1:0];
          end
        end
        default: r_next.dead = r_next.dead;
      endcase
    end

    if (do_wr && (idx == CTRL_IDX) && avs_byteenable_in[0]) begin
      r_next.ctrl.mode_select_bit = wd[MODE_BIT]; // R10
      r_next.ctrl.second_output_or_edge_bit = wd[EDGE_BIT]; // R11
      r_next.ctrl.first_output_enable_bit = wd[OUT1_BIT];
      r_next.ctrl.timer_irq_enable = wd[IRQEN_BIT];
      r_next.ctrl.strobe_pin_route = wd[ROUTE_BIT];
      r_next.ctrl.period_capture_pending = r_reg.ctrl.period_capture_pending && wd[PEND_BIT]; // R8
      if (r_reg.running && r_reg.act.capture) begin
        r_next.ctrl.run_or_overflow_bit = r_reg.ctrl.run_or_overflow_bit && wd[RUN_BIT]; // R8
      end else if (r_reg.running) begin
        r_next.stop_req = !wd[RUN_BIT]; // R2
      end else if (wd[MODE_BIT] || wd[RUN_BIT]) begin
        r_next.running = 1'b1; // R1
        r_next.counter = COUNT_ZERO;
        r_next.stop_req = 1'b0;
        r_next.dt_hold = 1'b0;
        r_next.act = attr_of(r_next.ctrl);
        r_next.ctrl.run_or_overflow_bit = wd[RUN_BIT] && !wd[MODE_BIT];
        r_next.out_one = 1'b0; // R15
        r_next.out_two = 1'b0;
        r_next.adc = 1'b0;
      end else begin
        r_next.ctrl.run_or_overflow_bit = 1'b0;
      end
    end

    // counter and compares
    if (r_reg.running && tick && !r_reg.act.capture) begin
      if (r_reg.dt_hold) begin
        r_next.counter = COUNT_ZERO;
      end else if (r_reg.counter == r_reg.period) begin
        r_next.counter = COUNT_ZERO; // R14
        r_next.ctrl.period_capture_pending = 1'b1; // R4
        r_next.out_two = 1'b0; // R17
        r_next.adc = 1'b0;
        r_next.dt_hold = 1'b1;
        r_next.dt_phase = 1'b1;
        dt_start = 1'b1;
      end else begin
        r_next.counter = COUNT_W'(r_reg.counter + 12'h001);
        if (r_reg.counter == r_reg.cmp_a) begin
          r_next.out_one = r_reg.act.en_one; // R16 R17
          r_next.dt_phase = 1'b0;
          dt_start = 1'b1; // R18
        end
        if (r_reg.counter == r_reg.cmp_b) begin
          r_next.adc = 1'b1; // R16 R17
        end
      end
    end else if (r_reg.running && tick) begin
      r_next.counter = COUNT_W'(r_reg.counter + 12'h001); // R20
      if (r_reg.counter == COUNT_MAX) begin
        r_next.ctrl.run_or_overflow_bit = 1'b1; // R3
        r_next.adc = 1'b0;
        r_next.dt_phase = 1'b1;
        dt_start = 1'b1;
      end else begin
        if (r_reg.counter == r_reg.cmp_a) begin
          r_next.out_one = r_reg.act.en_one; // R11
        end
        if (r_reg.counter == r_reg.cmp_b) begin
          r_next.adc = 1'b1;
        end
      end
    end

    // capture of the synchronised edge wins over a software write
    if (r_reg.running && r_reg.act.capture && cap_edge) begin
      r_next.period = r_reg.counter; // R19
      r_next.ctrl.period_capture_pending = 1'b1; // R5
    end

    // dead time completion
    dt_done_now = dt_done || (dt_start && (r_reg.dead == DEAD_RESET));
    if (r_reg.running && dt_done_now && !r_next.dt_phase) begin
      r_next.out_two = r_reg.act.en_two; // R18
    end else if (r_reg.running && dt_done_now) begin
      r_next.out_one = 1'b0; // R18
      r_next.dt_hold = 1'b0;
      r_next.act = attr_of(r_next.ctrl);
      if (r_reg.act.capture && !r_next.act.capture) begin
        r_next.running = 1'b0; // R20
      end else if (!r_reg.act.capture && r_reg.stop_req) begin
        r_next.running = 1'b0; // R2
        r_next.ctrl.run_or_overflow_bit = 1'b0;
        r_next.stop_req = 1'b0;
      end else if (!r_reg.act.capture && r_next.act.capture) begin
        r_next.ctrl.run_or_overflow_bit = 1'b0;
      end
      if (!r_next.running) begin
        r_next.counter = COUNT_ZERO; // R1
        r_next.out_two = 1'b0;
        r_next.adc = 1'b0;
      end
    end

    // capture disabled together with a clear overflow flag stops at once
    if (r_reg.running && r_reg.act.capture && !r_next.ctrl.mode_select_bit
        && !r_next.ctrl.run_or_overflow_bit) begin
      r_next.running = 1'b0; // R20
      r_next.counter = COUNT_ZERO;
      r_next.out_one = 1'b0; // R15
      r_next.out_two = 1'b0;
      r_next.adc = 1'b0;
      r_next.dt_hold = 1'b0;
      r_next.act = attr_of(r_next.ctrl);
    end

    if (!r_next.running) begin
      r_next.act = attr_of(r_next.ctrl);
    end

    // registered pin and interrupt outputs
    r_next.strobe_pin = r_next.act.route ? r_next.adc : gpio_strobe_pin_data_in; // R12
    r_next.two_drive = !r_next.act.capture;
    r_next.irq = r_next.ctrl.timer_irq_enable
               && (r_next.ctrl.period_capture_pending
                   || (r_next.act.capture && r_next.ctrl.run_or_overflow_bit)); // R6 R7
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
      r_reg.ctrl <= pwmtic_ctrl_type'(7'(CTRL_RESET)); // R21
      r_reg.period <= PERIOD_RESET;
      r_reg.cmp_a <= CMP_RESET;
      r_reg.cmp_b <= CMP_RESET;
      r_reg.dead <= DEAD_RESET;
      r_reg.sel <= PRESCALE_REGISTER_RESET;
      r_reg.counter <= COUNT_ZERO;
      r_reg.two_drive <= 1'b1;
      r_reg.wait_req <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // outputs
  assign avs_readdata_out = r_reg.rdata;
  assign avs_waitrequest_out = r_reg.wait_req;
  assign bridge_output_one_out = r_reg.out_one;
  assign bridge_output_two_out = r_reg.out_two;
  assign bridge_two_drive_out = r_reg.two_drive;
  assign adc_strobe_out = r_reg.adc;
  assign strobe_pin_out = r_reg.strobe_pin;
  assign timer_interrupt_out = r_reg.irq;
endmodule
`default_nettype wire

// ---- verilog/pwmtic_pkg.sv ----
// Purpose: shared constants and types of the pwm timer with input capture
// Assumes: byte address on the bus is four times the register index
// Notes: offsets are register indices
`default_nettype none
package pwmtic_pkg;
  // ==========================================================
  // widths
  localparam int COUNT_W = 12;
  localparam int DT_W = 5;
  localparam int SEL_W = 3;
  localparam int DIV_W = 7;
  localparam int IDX_W = 8;
  // ==========================================================
  // register indices
  localparam logic [IDX_W-1:0] CTRL_IDX = 8'hAE;
  localparam logic [IDX_W-1:0] DEAD_IDX = 8'hA5;
  localparam logic [IDX_W-1:0] PERIOD_IDX = 8'hB0;
  localparam logic [IDX_W-1:0] CMPA_IDX = 8'hB1;
  localparam logic [IDX_W-1:0] CMPB_IDX = 8'hB2;
  localparam logic [IDX_W-1:0] PRESCALE_REGISTER_IDX = 8'hB3;
  localparam logic [IDX_W-1:0] COUNT_IDX = 8'hB4;
  // ==========================================================
  // control field positions
  localparam int MODE_BIT = 7;
  localparam int EDGE_BIT = 6;
  localparam int OUT1_BIT = 5;
  localparam int RUN_BIT = 4;
  localparam int PEND_BIT = 3;
  localparam int IRQEN_BIT = 2;
  localparam int ROUTE_BIT = 0;
  // ==========================================================
  // reset values and counter limits
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] PERIOD_RESET = 12'hFFF;
  localparam logic [COUNT_W-1:0] CMP_RESET = 12'h000;
  localparam logic [DT_W-1:0] DEAD_RESET = 5'h00;
  localparam logic [SEL_W-1:0] PRESCALE_REGISTER_RESET = 3'h0;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 12'h000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 12'hFFF;
  // ==========================================================
  // types
  typedef struct packed {
    logic mode_select_bit;
    logic second_output_or_edge_bit;
    logic first_output_enable_bit;
    logic run_or_overflow_bit;
    logic period_capture_pending;
    logic timer_irq_enable;
    logic strobe_pin_route;
  } pwmtic_ctrl_type;

  typedef struct packed {
    logic capture;
    logic en_one;
    logic en_two;
    logic falling;
    logic route;
  } pwmtic_attr_type;

  typedef struct packed {
    logic busy;
    logic [DT_W-1:0] cnt;
  } pwmtic_dt_state_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } pwmtic_sync_state_type;
endpackage
`default_nettype wire

// ---- verilog/pwmtic_dead_time.sv ----
// Purpose: dead time delay counter on timer ticks
// Assumes: a start never arrives while busy
// Notes: a zero count is handled by the caller
`default_nettype none
module pwmtic_dead_time import pwmtic_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic start_in,
  input wire logic [DT_W-1:0] count_in,
  output logic done_out
);
  pwmtic_dt_state_type s_reg;
  pwmtic_dt_state_type s_next;
  logic [DT_W-1:0] cnt_inc;

  // ==========================================================
  // counting
  assign cnt_inc = DT_W'(s_reg.cnt + 5'h01);
  assign done_out = s_reg.busy && tick_in && (cnt_inc == count_in);

  always_comb begin
    s_next = s_reg;
    if (start_in && (count_in != DEAD_RESET)) begin
      s_next.busy = 1'b1;
      s_next.cnt = DEAD_RESET;
    end else if (done_out) begin
      s_next.busy = 1'b0;
    end else if (s_reg.busy && tick_in) begin
      s_next.cnt = cnt_inc;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/pwmtic_edge_sync.sv ----
// Purpose: synchronise the capture pin and detect the selected edge
// Assumes: pin is asynchronous to clk_in
// Notes: edge pulse is one clock wide
`default_nettype none
module pwmtic_edge_sync import pwmtic_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic falling_in,
  output logic edge_out
);
  pwmtic_sync_state_type s_reg;
  pwmtic_sync_state_type s_next;

  // ==========================================================
  // two stage synchroniser then edge compare
  always_comb begin
    s_next.s1 = pin_in;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
  end

  assign edge_out = falling_in ? (s_reg.s3 && !s_reg.s2) : (!s_reg.s3 && s_reg.s2);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// ---- tb/pwmtic_monitor.sv ----
// Purpose: port-level assertions for the pwm timer
// Assumes: single clock, synchronous active-low reset
// Notes: bound into every pwmtic_top instance
`default_nettype none
module pwmtic_monitor import pwmtic_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic bridge_output_one_out,
  input wire logic bridge_output_two_out,
  input wire logic adc_strobe_out,
  input wire logic timer_interrupt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ==========
  // register bus
  sequence req_s;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence answer_s;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  bus_answer_a: assert property (req_s |=> answer_s)
    else $error("bus answer not after exactly one wait state");
  bus_idle_a: assert property (!avs_read_in && !avs_write_in |-> avs_waitrequest_out)
    else $error("waitrequest low without a request");
  spare_bit_a: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in[9:2] == CTRL_IDX
    |-> avs_readdata_out[1] == 1'b0 && avs_readdata_out[31:8] == 24'h000000)
    else $error("spare control bit read as one");
  // ==========
  // outputs
  rest_after_reset_a: assert property ($rose(rst_n_in) |-> !bridge_output_one_out
    && !bridge_output_two_out && !adc_strobe_out && !timer_interrupt_out)
    else $error("outputs not at rest after reset");
  two_after_one_a: assert property ($rose(bridge_output_two_out) |-> bridge_output_one_out)
    else $error("output two rose before output one");
  one_after_two_a: assert property ($fell(bridge_output_one_out) |-> !bridge_output_two_out)
    else $error("output one fell before output two");
  strobe_with_two_a: assert property ($fell(bridge_output_two_out) |-> $fell(adc_strobe_out))
    else $error("strobe did not end with output two");
  irq_clear_a: assert property ($fell(timer_interrupt_out) |-> $past(avs_write_in && !avs_waitrequest_out, 1))
    else $error("interrupt dropped without a clearing write");
endmodule
bind pwmtic_top pwmtic_monitor mon (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .bridge_output_one_out(bridge_output_one_out),
  .bridge_output_two_out(bridge_output_two_out), .adc_strobe_out(adc_strobe_out),
  .timer_interrupt_out(timer_interrupt_out));
`default_nettype wire

// ---- tb/pwmtic_bridge_model.sv ----
// Purpose: half-bridge driver side and capture signal source
// Assumes: pin two is shared, the timer drives it while its enable is high
// Notes: the bench moves the source level through set_pin
`default_nettype none
module pwmtic_bridge_model (
  input wire logic clk_in,
  input wire logic bridge_output_one_in,
  input wire logic bridge_output_two_in,
  input wire logic bridge_two_drive_in,
  output logic capture_pin_out,
  output logic shoot_through_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic src_reg = 1'b0;
  logic fault_reg = 1'b0;
  // pin level resolved from both drivers
  assign capture_pin_out = bridge_two_drive_in ? bridge_output_two_in : src_reg;
  assign shoot_through_out = fault_reg;
  // low side on without high side is a driver hazard
  always @(posedge clk_in) begin
    if (bridge_two_drive_in && bridge_output_two_in && !bridge_output_one_in) fault_reg <= 1'b1;
  end
  task set_pin(input logic v);
    @(posedge clk_in);
    src_reg <= v;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the pwm timer with input capture
// Assumes: 100 MHz clock, reset held five cycles
// Notes: register rows first, then routing, pwm timing, stop and capture
`default_nettype none
module tb import pwmtic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [9:0] a;
    logic [31:0] d;
    logic [3:0] be;
    logic [31:0] e;
  } pwmtic_row_type;
  localparam logic [9:0] A_CTRL = {CTRL_IDX, 2'b00};
  localparam logic [9:0] A_DEAD = {DEAD_IDX, 2'b00};
  localparam logic [9:0] A_PER = {PERIOD_IDX, 2'b00};
  localparam logic [9:0] A_CA = {CMPA_IDX, 2'b00};
  localparam logic [9:0] A_CB = {CMPB_IDX, 2'b00};
  localparam logic [9:0] A_PSC = {PRESCALE_REGISTER_IDX, 2'b00};
  localparam logic [9:0] A_CNT = {COUNT_IDX, 2'b00};
  localparam int DT = 32'h3;
  localparam int PER = 32'h40;
  localparam int CA = 32'h10;
  localparam int CB = 32'h20;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [9:0] address = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] be = 4'h0;
  logic gpio = 1'b0;
  logic [31:0] rdata;
  logic wait_o, one, two, drv, adc, pin_s, irq, cap, fault;
  logic p1 = 1'b0;
  logic p2 = 1'b0;
  logic pa = 1'b0;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int r1, r2, ra, f1, f2, fa;
  pwmtic_row_type rows [12] = '{
    '{A_DEAD, 32'h000000FF, 4'h1, 32'h0000001F}, '{A_PER, 32'h0000FABC, 4'h3, 32'h00000ABC},
    '{A_PER, 32'h00000055, 4'h1, 32'h00000A55}, '{A_PER, 32'h00000040, 4'h3, 32'h00000040},
    '{A_CA, 32'h00000010, 4'h3, 32'h00000010}, '{A_CB, 32'h00000020, 4'h3, 32'h00000020},
    '{A_PSC, 32'h000000FF, 4'h1, 32'h00000007}, '{A_CNT, 32'h00000123, 4'h3, 32'h00000000},
    '{10'h000, 32'h000000FF, 4'hF, 32'h00000000}, '{A_CTRL, 32'h0000000E, 4'h1, 32'h00000004},
    '{A_CTRL, 32'h00000000, 4'h1, 32'h00000000}, '{A_DEAD, 32'h00000003, 4'h1, 32'h00000003}};
  pwmtic_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(address), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_o), .capture_pin_in(cap), .gpio_strobe_pin_data_in(gpio),
    .bridge_output_one_out(one), .bridge_output_two_out(two), .bridge_two_drive_out(drv),
    .adc_strobe_out(adc), .strobe_pin_out(pin_s), .timer_interrupt_out(irq));
  pwmtic_bridge_model bridge (.clk_in(clk_in), .bridge_output_one_in(one), .bridge_output_two_in(two),
    .bridge_two_drive_in(drv), .capture_pin_out(cap), .shoot_through_out(fault));
  always #5 clk_in = ~clk_in;
  // ==========
  // edge time stamps
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    p1 <= one;
    p2 <= two;
    pa <= adc;
    if (one && !p1) r1 <= cyc;
    if (!one && p1) f1 <= cyc;
    if (two && !p2) r2 <= cyc;
    if (!two && p2) f2 <= cyc;
    if (adc && !pa) ra <= cyc;
    if (!adc && pa) fa <= cyc;
  end
  // ==========
  // tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
    @(posedge clk_in);
    address <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    be <= b;
    do begin
      @(posedge clk_in);
    end while (wait_o !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rdc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 4'hF, q);
    chk(q, e);
  endtask
  task wait_sig(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while ((s == 0 ? one : (s == 1 ? irq : adc)) !== v && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      $display("CHECK FAILED t=%0t wait for signal %0d timed out", $time, s);
    end
  endtask
  task test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    logic [31:0] q;
    logic [31:0] c1;
    logic [31:0] p;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk({28'h0000000, one, two, adc, irq}, 32'h00000000);
    rdc(A_CTRL, 32'h00000000);
    rdc(A_PER, 32'h00000FFF);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].be, q);
      rdc(rows[i].a, rows[i].e);
    end
    gpio <= 1'b1;
    bus(1'b1, A_CTRL, 32'h00000001, 4'h1, q);
    repeat (2) @(posedge clk_in);
    chk(pin_s, 32'h00000000);
    bus(1'b1, A_CTRL, 32'h00000000, 4'h1, q);
    repeat (2) @(posedge clk_in);
    chk(pin_s, 32'h00000001);
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, A_PSC, 32'(s), 4'h1, q);
      bus(1'b1, A_CTRL, 32'h00000074, 4'h1, q);
      wait_sig(0, 1'b1, 800);
      wait_sig(0, 1'b0, 800);
      @(posedge clk_in);
      chk(r2 - r1, DT << s);
      chk(ra - r1, (CB - CA) << s);
      chk(fa - ra, (PER - CB) << s);
      chk(f2, fa);
      chk(f1 - f2, DT << s);
      chk(irq, 32'h00000001);
      bus(1'b1, A_CTRL, 32'h0000007C, 4'h1, q);
      repeat (2) @(posedge clk_in);
      chk(irq, 32'h00000001);
      bus(1'b1, A_CTRL, 32'h00000074, 4'h1, q);
      repeat (2) @(posedge clk_in);
      chk(irq, 32'h00000000);
      wait_sig(0, 1'b1, 800);
      bus(1'b1, A_CTRL, 32'h00000064, 4'h1, q);
      rdc(A_CTRL, 32'h00000074);
      wait_sig(2, 1'b1, 800);
      chk(adc, 32'h00000001);
      wait_sig(0, 1'b0, 800);
      repeat (4) @(posedge clk_in);
      rdc(A_CTRL, 32'h0000006C);
      rdc(A_CNT, 32'h00000000);
      repeat (100) @(posedge clk_in);
      chk({one, adc}, 32'h00000000);
    end
    bus(1'b1, A_PSC, 32'h00000000, 4'h1, q);
    bus(1'b1, A_CTRL, 32'h000000C4, 4'h1, q);
    bridge.set_pin(1'b1);
    repeat (6) @(posedge clk_in);
    chk(irq, 32'h00000000);
    chk(drv, 32'h00000000);
    bus(1'b0, A_CNT, 32'h00000000, 4'hF, c1);
    bridge.set_pin(1'b0);
    wait_sig(1, 1'b1, 5);
    chk(irq, 32'h00000001);
    bus(1'b0, A_PER, 32'h00000000, 4'hF, p);
    bus(1'b0, A_CNT, 32'h00000000, 4'hF, q);
    chk({31'h00000000, c1 < p && p < q}, 32'h00000001);
    rdc(A_CTRL, 32'h000000CC);
    bus(1'b1, A_CTRL, 32'h000000C4, 4'h1, q);
    repeat (2) @(posedge clk_in);
    chk(irq, 32'h00000000);
    wait_sig(1, 1'b1, 4200);
    rdc(A_CTRL, 32'h000000D4);
    bus(1'b1, A_CTRL, 32'h00000000, 4'h1, q);
    repeat (2) @(posedge clk_in);
    rdc(A_CNT, 32'h00000000);
    chk({irq, fault}, 32'h00000000);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
